//--- core/usic_defs.svh
// Offsets, field positions and reset values of the serial interface control block.
`ifndef USIC_DEFS_SVH
`define USIC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define USIC_OFF_CTRL 8'h00
`define USIC_OFF_DATA 8'h04
`define USIC_OFF_STAT 8'h08
`define USIC_OFF_PORT 8'h0c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define USIC_CTRL_TOGGLE 0
`define USIC_CTRL_STROBE 1
`define USIC_STAT_OIF 6
`define USIC_STAT_SIF 7
`define USIC_PORT_DIR_LSB 4

// ----------------------------------------------------------------------------
// Reset values and counter maximum
// ----------------------------------------------------------------------------
`define USIC_RST_BYTE 8'h00
`define USIC_RST_CNT 4'h0
`define USIC_RST_PORT 3'h0
`define USIC_CNT_MAX 4'hf

`endif

//--- core/usic_pkg.sv
// Types of the serial interface control block.
package usic_pkg;

  typedef enum logic [1:0] {
    USIC_WM_OFF = 2'b00,
    USIC_WM_THREE = 2'b01,
    USIC_WM_TWO = 2'b10,
    USIC_WM_TWO_HOLD = 2'b11
  } usic_wm_t;

  typedef enum logic [1:0] {
    USIC_CS_SOFT = 2'b00,
    USIC_CS_TIMER = 2'b01,
    USIC_CS_EXT_POS = 2'b10,
    USIC_CS_EXT_NEG = 2'b11
  } usic_cs_t;

endpackage : usic_pkg

//--- core/usic_ctrl.sv
// Wire-mode and clock-source control of the universal serial interface, with an APB slave.
`timescale 1ns/1ps
`include "usic_defs.svh"


module usic_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_ovf,
  input wire logic pin0_i,
  output logic pin0_o,
  output logic pin0_oe,
  output logic pin0_pu,
  output logic pin1_o,
  output logic pin1_oe,
  output logic pin1_pu,
  input wire logic pin2_i,
  output logic pin2_o,
  output logic pin2_oe,
  output logic pin2_pu,
  output usic_pkg::usic_wm_t wire_mode,
  output logic [3:0] count
);
  import usic_pkg::*;

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic acc, wr;
  logic hit_ctrl, hit_data, hit_stat, hit_port, hit;
  logic ctrl_wr, data_wr, stat_wr, port_wr;
  logic [7:0] rd_byte;

  assign acc = psel & penable & ~pready_q;
  assign wr = psel & penable & pwrite & pready_q;
  assign hit_ctrl = paddr == `USIC_OFF_CTRL;
  assign hit_data = paddr == `USIC_OFF_DATA;
  assign hit_stat = paddr == `USIC_OFF_STAT;
  assign hit_port = paddr == `USIC_OFF_PORT;
  assign hit = hit_ctrl | hit_data | hit_stat | hit_port;
  assign ctrl_wr = wr & hit_ctrl;
  assign data_wr = wr & hit_data;
  assign stat_wr = wr & hit_stat;
  assign port_wr = wr & hit_port;

  // ----------------------------------------------------------------------------
  // Control, status and port state
  // ----------------------------------------------------------------------------
  logic [1:0] ie_q;
  usic_wm_t wm_q;
  usic_cs_t cs_q;
  logic clk_sel_q;
  logic [7:0] sr_q, sr_d;
  logic [3:0] cnt_q, cnt_d;
  logic sif_q, oif_q;
  logic [2:0] port_q, port_d, dir_q;
  logic lat_q, do_bit;

  always_comb begin
    if (hit_ctrl) begin
      // Strobe and toggle read as zero; the strobe bit reads back only as an external-clock select.
      rd_byte = {ie_q, wm_q, cs_q, clk_sel_q & cs_q[1], 1'b0};
    end else if (hit_data) begin
      rd_byte = sr_q;
    end else if (hit_stat) begin
      rd_byte = {sif_q, oif_q, 2'b00, cnt_q};
    end else if (hit_port) begin
      rd_byte = {1'b0, dir_q, 1'b0, port_q};
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & ~hit;
      prdata_q <= acc ? {24'h00_0000, rd_byte} : prdata_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Clock and data pin synchronisers and edge detection
  // ----------------------------------------------------------------------------
  logic [1:0] scl_sy_q, sda_sy_q;
  logic scl_dl_q, sda_dl_q;
  logic rise, fall, sda_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Both lines idle high on their pull-ups, so the detectors start high to avoid a false edge after reset.
      scl_sy_q <= 2'b11;
      sda_sy_q <= 2'b11;
      scl_dl_q <= 1'b1;
      sda_dl_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], pin2_i};
      sda_sy_q <= {sda_sy_q[0], pin0_i};
      scl_dl_q <= scl_sy_q[1];
      sda_dl_q <= sda_sy_q[1];
    end
  end

  assign rise = scl_sy_q[1] & ~scl_dl_q;
  assign fall = ~scl_sy_q[1] & scl_dl_q;
  assign sda_fall = ~sda_sy_q[1] & sda_dl_q;

  // ----------------------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------------------
  logic sw_strobe, tog_wr, tog_cnt, tmr_sel, ext_shift, ext_cnt;
  logic shift_en, cnt_en, opp_edge;
  logic ovf_evt, start_evt, hold;

  // A strobe shifts and counts only when the same write leaves the source select at zero; with toggle and bit 3 set it only counts.
  assign sw_strobe = ctrl_wr & pwdata[`USIC_CTRL_STROBE] & (pwdata[3:2] == USIC_CS_SOFT);
  assign tog_wr = ctrl_wr & pwdata[`USIC_CTRL_TOGGLE];
  assign tog_cnt = tog_wr & pwdata[3] & pwdata[`USIC_CTRL_STROBE];
  assign tmr_sel = (cs_q == USIC_CS_TIMER) & timer_ovf;
  assign ext_shift = cs_q[1] & (cs_q[0] ? fall : rise);
  assign ext_cnt = cs_q[1] & ~clk_sel_q & (rise | fall);
  assign shift_en = sw_strobe | tmr_sel | ext_shift;
  assign cnt_en = sw_strobe | tmr_sel | ext_cnt | tog_cnt;
  assign opp_edge = cs_q[0] ? rise : fall;

  // A register write wins over a shift or count in the same cycle.
  assign sr_d = data_wr ? pwdata[7:0] : (shift_en ? {sr_q[6:0], sda_sy_q[1]} : sr_q);
  assign cnt_d = stat_wr ? pwdata[3:0] : (cnt_en ? cnt_q + 4'h1 : cnt_q);
  assign ovf_evt = cnt_en & ~stat_wr & (cnt_q == `USIC_CNT_MAX);
  assign start_evt = wm_q[1] & sda_fall & scl_sy_q[1];
  assign hold = wm_q[1] & (sif_q | ((wm_q == USIC_WM_TWO_HOLD) & oif_q));
  assign port_d = port_wr ? pwdata[2:0] : port_q;
  assign do_bit = cs_q[1] ? lat_q : sr_q[7];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 2'b00;
      wm_q <= USIC_WM_OFF;
      cs_q <= USIC_CS_SOFT;
      clk_sel_q <= 1'b0;
      sr_q <= `USIC_RST_BYTE;
      cnt_q <= `USIC_RST_CNT;
      sif_q <= 1'b0;
      oif_q <= 1'b0;
      port_q <= `USIC_RST_PORT;
      dir_q <= `USIC_RST_PORT;
      lat_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ie_q <= pwdata[7:6];
        wm_q <= usic_wm_t'(pwdata[5:4]);
        cs_q <= usic_cs_t'(pwdata[3:2]);
        clk_sel_q <= pwdata[`USIC_CTRL_STROBE];
      end
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      // Set wins over a clear written in the same cycle.
      sif_q <= start_evt | (sif_q & ~(stat_wr & pwdata[`USIC_STAT_SIF]));
      oif_q <= ovf_evt | (oif_q & ~(stat_wr & pwdata[`USIC_STAT_OIF]));
      port_q <= {port_d[2] ^ tog_wr, port_d[1:0]};
      if (port_wr) begin
        dir_q <= pwdata[`USIC_PORT_DIR_LSB +: 3];
      end
      if (~cs_q[1] | opp_edge) begin
        lat_q <= sr_q[7];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------------
  logic two_wire, three_wire;
  assign two_wire = wm_q[1];
  assign three_wire = wm_q == USIC_WM_THREE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_o <= 1'b0;
      pin0_oe <= 1'b0;
      pin0_pu <= 1'b0;
      pin1_o <= 1'b0;
      pin1_oe <= 1'b0;
      pin1_pu <= 1'b0;
      pin2_o <= 1'b0;
      pin2_oe <= 1'b0;
      pin2_pu <= 1'b0;
    end else begin
      pin0_o <= two_wire ? 1'b0 : port_q[0];
      pin0_oe <= dir_q[0] & (~two_wire | ~(do_bit & port_q[0]));
      pin0_pu <= ~dir_q[0] & port_q[0] & ~two_wire;
      pin1_o <= three_wire ? do_bit : port_q[1];
      pin1_oe <= dir_q[1];
      pin1_pu <= ~dir_q[1] & port_q[1];
      pin2_o <= two_wire ? 1'b0 : port_q[2];
      pin2_oe <= dir_q[2] & (~two_wire | ~port_q[2] | hold);
      pin2_pu <= ~dir_q[2] & port_q[2] & ~two_wire;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wire_mode = wm_q;
  assign count = cnt_q;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mode_off_a: assert property ((wm_q == USIC_WM_OFF) |=> pin0_oe == $past(dir_q[0]) && pin0_o == $past(port_q[0]))
    else $error("Disabled mode altered the data pin.");
  three_out_a: assert property (three_wire && !$past(cs_q[1]) && !cs_q[1] |=> pin1_o == $past(sr_q[7]))
    else $error("Three-wire output does not follow the shifter.");
  sda_drive_a: assert property (two_wire && dir_q[0] && !port_q[0] |=> pin0_oe && !pin0_o)
    else $error("Data line not pulled low.");
  scl_hold_a: assert property (two_wire && sif_q && dir_q[2] |=> pin2_oe && !pin2_o)
    else $error("Start hold did not pull the clock low.");
  ovf_hold_a: assert property ((wm_q == USIC_WM_TWO_HOLD) && oif_q && dir_q[2] |=> pin2_oe)
    else $error("Overflow hold did not pull the clock low.");
  pullup_off_a: assert property (two_wire |=> !pin0_pu && !pin2_pu)
    else $error("Pull-up active in two-wire mode.");
  cnt_wrap_a: assert property (cnt_en && !stat_wr && cnt_q == 4'hf |=> oif_q && cnt_q == 4'h0)
    else $error("Counter wrap did not set the overflow flag.");
  ext_edge_a: assert property (cs_q == USIC_CS_EXT_NEG && fall && !data_wr |=> sr_q == {$past(sr_q[6:0]), $past(sda_sy_q[1])})
    else $error("Falling clock edge did not shift the register.");
  strobe_step_a: assert property (sw_strobe && !data_wr |=> sr_q == {$past(sr_q[6:0]), $past(sda_sy_q[1])})
    else $error("Strobe did not shift the register.");
  toggle_inv_a: assert property (tog_wr && !port_wr |=> port_q[2] != $past(port_q[2]))
    else $error("Toggle did not invert port bit two.");
  edge_pulse_a: assert property (rise |=> !rise)
    else $error("Edge pulse wider than one cycle.");
  tmr_src_a: assert property (cs_q == USIC_CS_TIMER && timer_ovf && !stat_wr && !ctrl_wr |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("Timer overflow did not clock the counter.");

  full_count_c: cover property (ovf_evt);
  start_seen_c: cover property (start_evt ##[1:20] (stat_wr && pwdata[7]));
  ext_shift_c: cover property (ext_shift && cs_q[0]);
  tog_count_c: cover property (tog_cnt);

endmodule : usic_ctrl

//--- tb/usic_peer.sv
// Remote serial master model on the open-drain data and clock lines.
`timescale 1ns/1ps
module usic_peer (
  output logic sda_low,
  output logic scl_low
);
  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
  end
  // The clock pulses n times per call, with no frame needed, at a 64 ns period, and rests high on the pull-up.
  task automatic pulses(input int n);
    repeat (n) begin
      #32 scl_low = 1'b1;
      #32 scl_low = 1'b0;
    end
  endtask : pulses
  // Data falls while the clock is high, and is released only once the clock is low.
  task automatic start_cond();
    #32 sda_low = 1'b1;
    #64 scl_low = 1'b1;
    #32 sda_low = 1'b0;
    #32 scl_low = 1'b0;
  endtask : start_cond
endmodule : usic_peer

//--- tb/test_serial_iface_mode_clock_ctrl.sv
// Self-checking testbench of the serial interface control block.
`timescale 1ns/1ps
`include "usic_defs.svh"
module test_serial_iface_mode_clock_ctrl;
  import usic_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic timer_ovf = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, pin0_o, pin0_oe, pin0_pu, pin1_o, pin1_oe, pin1_pu, pin2_o, pin2_oe, pin2_pu;
  logic sda_low, scl_low;
  usic_wm_t wire_mode;
  logic [3:0] count;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  wire pin0_i = ~((pin0_oe & ~pin0_o) | sda_low);
  wire pin2_i = ~((pin2_oe & ~pin2_o) | scl_low);
  usic_ctrl usic_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timer_ovf, .pin0_i, .pin0_o, .pin0_oe, .pin0_pu, .pin1_o, .pin1_oe, .pin1_pu, .pin2_i, .pin2_o, .pin2_oe,
    .pin2_pu, .wire_mode, .count);
  usic_peer usic_peer_i (.sda_low, .scl_low);
  always #2.5 pclk = ~pclk;
  // --------------------------------------------------------------------------
  // Bus and checking tasks
  // --------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask : settle
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    rchk("ctrl reset", `USIC_OFF_CTRL, 32'h0);
    rchk("unmapped data", 8'h10, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
  endtask : t_reset
  task automatic t_soft();
    apb(1'b1, `USIC_OFF_PORT, 32'h20);
    apb(1'b1, `USIC_OFF_CTRL, 32'h10);
    apb(1'b1, `USIC_OFF_DATA, 32'h80);
    settle();
    chk("three-wire data out", 32'h1, {31'h0, pin1_o});
    chk("data-out drive and pull-up", 32'h2, {30'h0, pin1_oe, pin1_pu});
    apb(1'b1, `USIC_OFF_CTRL, 32'h12);
    settle();
    chk("strobe count", 32'h1, {28'h0, count});
    chk("shifted data out", 32'h0, {31'h0, pin1_o});
    rchk("strobe reads zero", `USIC_OFF_CTRL, 32'h10);
    rchk("shift in", `USIC_OFF_DATA, 32'h01);
    apb(1'b1, `USIC_OFF_CTRL, 32'h10);
    settle();
    chk("no clock", 32'h1, {28'h0, count});
    apb(1'b1, `USIC_OFF_CTRL, 32'h14);
    @(posedge pclk);
    timer_ovf <= 1'b1;
    @(posedge pclk);
    timer_ovf <= 1'b0;
    settle();
    chk("timer count", 32'h2, {28'h0, count});
  endtask : t_soft
  task automatic t_toggle();
    apb(1'b1, `USIC_OFF_CTRL, 32'h11);
    rchk("toggled port", `USIC_OFF_PORT, 32'h24);
    rchk("toggle reads zero", `USIC_OFF_CTRL, 32'h10);
    chk("clock pin undriven", 32'h0, {31'h0, pin2_oe});
  endtask : t_toggle
  task automatic t_ext();
    apb(1'b1, `USIC_OFF_CTRL, 32'h0c);
    apb(1'b1, `USIC_OFF_STAT, 32'h00);
    apb(1'b1, `USIC_OFF_DATA, 32'h00);
    usic_peer_i.pulses(1);
    settle();
    chk("edges counted", 32'h2, {28'h0, count});
    rchk("external shift", `USIC_OFF_DATA, 32'h01);
    chk("port clock value", 32'h1, {31'h0, pin2_o});
    apb(1'b1, `USIC_OFF_CTRL, 32'h0b);
    settle();
    chk("toggle count", 32'h3, {28'h0, count});
    apb(1'b1, `USIC_OFF_CTRL, 32'h18);
    apb(1'b1, `USIC_OFF_DATA, 32'h80);
    usic_peer_i.pulses(1);
    settle();
    chk("latched data out", 32'h1, {31'h0, pin1_o});
  endtask : t_ext
  task automatic t_two();
    apb(1'b1, `USIC_OFF_PORT, 32'h55);
    apb(1'b1, `USIC_OFF_CTRL, 32'h20);
    apb(1'b1, `USIC_OFF_DATA, 32'h80);
    settle();
    chk("mode", USIC_WM_TWO, {30'h0, wire_mode});
    chk("data released", 32'h1, {31'h0, pin0_i});
    chk("open-drain data level", 32'h0, {31'h0, pin0_o});
    chk("pull-ups", 32'h0, {30'h0, pin0_pu, pin2_pu});
    apb(1'b1, `USIC_OFF_DATA, 32'h00);
    settle();
    chk("data pulled", 32'h0, {31'h0, pin0_i});
    apb(1'b1, `USIC_OFF_DATA, 32'h80);
    apb(1'b1, `USIC_OFF_STAT, 32'hc3);
    usic_peer_i.start_cond();
    settle();
    rchk("start flag", `USIC_OFF_STAT, 32'h83);
    chk("start hold", 32'h0, {31'h0, pin2_i});
    apb(1'b1, `USIC_OFF_STAT, 32'h83);
    settle();
    chk("start release", 32'h1, {31'h0, pin2_i});
  endtask : t_two
  task automatic t_ovf();
    apb(1'b1, `USIC_OFF_CTRL, 32'h30);
    apb(1'b1, `USIC_OFF_STAT, 32'h0f);
    apb(1'b1, `USIC_OFF_CTRL, 32'h32);
    settle();
    rchk("overflow flag", `USIC_OFF_STAT, 32'h40);
    chk("overflow hold", 32'h0, {31'h0, pin2_i});
    apb(1'b1, `USIC_OFF_STAT, 32'h40);
    settle();
    chk("overflow release", 32'h1, {31'h0, pin2_i});
    apb(1'b1, `USIC_OFF_PORT, 32'h05);
    settle();
    chk("pull-ups off as inputs", 32'h0, {30'h0, pin0_pu, pin2_pu});
  endtask : t_ovf
  // --------------------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_soft();
    t_toggle();
    t_ext();
    t_two();
    t_ovf();
    summarize();
  end
endmodule : test_serial_iface_mode_clock_ctrl
